/* File: design/tcc16_timer.sv */
`timescale 1ns/1ps
`include "tcc16_regs.svh"
module tcc16_timer (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire tcc16_pkg::tcc16_req_t req,
    output logic [15:0] rdata_q,
    input wire logic ext_input_a,
    input wire logic ext_input_b,
    input wire logic other_timer_irq,
    output logic timer_out_pin,
    output logic match_irq_a,
    output logic match_irq_b
);
    import tcc16_pkg::*;

    logic [7:0] mode_control_q;
    logic [7:0] capcmp_control_q;
    logic [7:0] output_control_q;
    logic [7:0] prescaler_select_q;
    logic [15:0] count_value_q;
    logic [15:0] capcmp_a_q;
    logic [15:0] capcmp_b_q;
    logic [3:0] pre_q;
    logic pend_q;
    logic lv_q;
    logic [2:0] in_a_q;
    logic [2:0] in_b_q;
    logic [1:0] warm_q;
    logic sync_ok;

    tcc16_mode_t mode;
    tcc16_clk_sel_t clk_sel;
    logic running, wr_mode, wr_oc, wr_pre, wr_cc, read_cnt;
    logic rise_a, fall_a, rise_b, fall_b, edge_a_hit, edge_b_hit, cap_a_trig;
    logic raw_tick, tick, cmp_a_hit, cmp_b_hit, clr_evt, sw_trig, oneshot;
    logic cap_a_mode, cap_b_mode;

    function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
        case (sel)
            2'h0: edge_hit = fall;
            2'h1: edge_hit = rise;
            2'h3: edge_hit = rise | fall;
            default: edge_hit = 1'b0;
        endcase
    endfunction : edge_hit

    function automatic logic hit(input tcc16_req_t r, input logic [15:0] a);
        hit = r.wr && (r.addr == a);
    endfunction : hit

    // The second and third stages feed the edge detector
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            in_a_q <= 3'h0;
            in_b_q <= 3'h0;
        end else begin
            in_a_q <= {in_a_q[1:0], ext_input_a};
            in_b_q <= {in_b_q[1:0], ext_input_b};
        end
    end

    // Edges wait until the edge stage holds a real pin sample: the stages reset
    // to zero while a pin may idle high, which would look like a rising edge
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            warm_q <= 2'h0;
        end else if (!sync_ok) begin
            warm_q <= warm_q + 2'h1;
        end
    end

    assign sync_ok = (warm_q == 2'h3);
    assign rise_a = sync_ok & in_a_q[1] & ~in_a_q[2];
    assign fall_a = sync_ok & ~in_a_q[1] & in_a_q[2];
    assign rise_b = sync_ok & in_b_q[1] & ~in_b_q[2];
    assign fall_b = sync_ok & ~in_b_q[1] & in_b_q[2];

    assign mode = tcc16_mode_t'(mode_control_q[`TCC16_MODE_SEL_LSB +: 2]);
    assign running = (mode != TCC16_STOP);
    assign clk_sel = tcc16_clk_sel_t'(prescaler_select_q[`TCC16_PRE_CLK_LSB +: 2]);
    assign cap_a_mode = capcmp_control_q[`TCC16_CC_A_CAP_BIT];
    assign cap_b_mode = capcmp_control_q[`TCC16_CC_B_CAP_BIT];
    assign oneshot = output_control_q[`TCC16_OC_ONESHOT_BIT];

    assign edge_a_hit = running & edge_hit(prescaler_select_q[`TCC16_PRE_EDGE_A_LSB +: 2], rise_a, fall_a);
    assign edge_b_hit = running & edge_hit(prescaler_select_q[`TCC16_PRE_EDGE_B_LSB +: 2], rise_b, fall_b);

    // Reverse phase: rise and fall are swapped, and the both-edge code is masked off so it captures nothing
    always_comb begin
        if (capcmp_control_q[`TCC16_CC_A_SRC_BIT]) begin
            cap_a_trig = running & (prescaler_select_q[`TCC16_PRE_EDGE_A_LSB +: 2] != 2'h3)
                & edge_hit(prescaler_select_q[`TCC16_PRE_EDGE_A_LSB +: 2], fall_a, rise_a);
        end else begin
            cap_a_trig = edge_b_hit;
        end
    end

    assign wr_mode = hit(req, `TCC16_ADDR_MODE_CTRL);
    assign wr_cc = hit(req, `TCC16_ADDR_CAPCMP_CTRL);
    assign wr_oc = hit(req, `TCC16_ADDR_OUTPUT_CTRL);
    assign wr_pre = hit(req, `TCC16_ADDR_PRESCALER);
    assign sw_trig = wr_oc & req.wdata[`TCC16_OC_TRIG_BIT];
    assign read_cnt = req.rd && (req.addr == `TCC16_ADDR_COUNT);

    always_comb begin
        case (clk_sel)
            TCC16_CLK_DIV4: raw_tick = ((pre_q & `TCC16_DIV4_LAST) == `TCC16_DIV4_LAST);
            TCC16_CLK_DIV16: raw_tick = (pre_q == `TCC16_DIV16_LAST);
            TCC16_CLK_OTHER_IRQ: raw_tick = other_timer_irq;
            TCC16_CLK_EDGE_A: raw_tick = edge_a_hit;
            default: raw_tick = 1'b0;
        endcase
    end

    // A tick that meets a count read is delayed one cycle, not dropped
    assign tick = running & ((raw_tick & ~read_cnt) | pend_q);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pre_q <= 4'h0;
            pend_q <= 1'b0;
        end else begin
            pre_q <= running ? pre_q + 4'h1 : 4'h0;
            pend_q <= running & raw_tick & read_cnt;
        end
    end

    assign cmp_a_hit = tick & ~cap_a_mode & (count_value_q == capcmp_a_q);
    assign cmp_b_hit = tick & ~cap_b_mode & (count_value_q == capcmp_b_q);
    assign clr_evt = ((mode == TCC16_CLEAR_EDGE) & edge_a_hit)
        | ((mode == TCC16_CLEAR_MATCH) & cmp_a_hit)
        | (running & oneshot & (sw_trig | edge_a_hit));

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_value_q <= `TCC16_RST_WORD;
        end else if (!running || clr_evt) begin
            count_value_q <= `TCC16_RST_WORD;
        end else if (tick) begin
            count_value_q <= count_value_q + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_control_q <= `TCC16_RST_BYTE;
        end else begin
            if (wr_mode) begin
                mode_control_q[3:1] <= req.wdata[3:1];
            end
            // Hardware set beats a software clear in the same cycle
            if (tick && count_value_q == `TCC16_COUNT_MAX) begin
                mode_control_q[`TCC16_MODE_OVF_BIT] <= 1'b1;
            end else if (wr_mode) begin
                mode_control_q[`TCC16_MODE_OVF_BIT] <= req.wdata[`TCC16_MODE_OVF_BIT];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            capcmp_control_q <= `TCC16_RST_BYTE;
            output_control_q <= `TCC16_RST_BYTE;
            prescaler_select_q <= `TCC16_RST_BYTE;
        end else begin
            if (wr_cc) capcmp_control_q <= req.wdata[7:0] & `TCC16_CC_WR_MASK;
            if (wr_oc) output_control_q <= req.wdata[7:0] & `TCC16_OC_STORE_MASK;
            if (wr_pre) prescaler_select_q <= req.wdata[7:0] & `TCC16_PRE_WR_MASK;
        end
    end

    // Byte writes to the capture registers are ignored
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            capcmp_a_q <= `TCC16_RST_WORD;
            capcmp_b_q <= `TCC16_RST_WORD;
        end else begin
            if (cap_a_mode && cap_a_trig) capcmp_a_q <= count_value_q;
            else if (hit(req, `TCC16_ADDR_CAPCMP_A) && req.word) capcmp_a_q <= req.wdata;
            if (cap_b_mode && edge_a_hit) capcmp_b_q <= count_value_q;
            else if (hit(req, `TCC16_ADDR_CAPCMP_B) && req.word) capcmp_b_q <= req.wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            match_irq_a <= 1'b0;
            match_irq_b <= 1'b0;
        end else begin
            match_irq_a <= running & (cmp_a_hit | (cap_a_mode & cap_a_trig));
            match_irq_b <= running & (cmp_b_hit | (cap_b_mode & edge_a_hit));
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            lv_q <= 1'b0;
        end else if (wr_oc && req.wdata[`TCC16_OC_SET_BIT] && !req.wdata[`TCC16_OC_RESET_BIT]) begin
            lv_q <= 1'b1;
        end else if (wr_oc && req.wdata[`TCC16_OC_RESET_BIT] && !req.wdata[`TCC16_OC_SET_BIT]) begin
            lv_q <= 1'b0;
        end else if ((output_control_q[`TCC16_OC_TOG_A_BIT] && (cmp_a_hit
                || (mode_control_q[`TCC16_MODE_TIMING_BIT] && edge_a_hit)))
                || (output_control_q[`TCC16_OC_TOG_B_BIT] && cmp_b_hit)) begin
            lv_q <= ~lv_q;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            timer_out_pin <= 1'b0;
        end else begin
            timer_out_pin <= lv_q & output_control_q[`TCC16_OC_ENABLE_BIT];
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= `TCC16_RST_WORD;
        end else if (req.rd) begin
            case (req.addr)
                `TCC16_ADDR_COUNT: rdata_q <= count_value_q;
                `TCC16_ADDR_CAPCMP_A: rdata_q <= capcmp_a_q;
                `TCC16_ADDR_CAPCMP_B: rdata_q <= capcmp_b_q;
                `TCC16_ADDR_CAPCMP_CTRL: rdata_q <= {8'h00, capcmp_control_q};
                `TCC16_ADDR_MODE_CTRL: rdata_q <= {8'h00, mode_control_q};
                `TCC16_ADDR_OUTPUT_CTRL: rdata_q <= {8'h00, output_control_q};
                `TCC16_ADDR_PRESCALER: rdata_q <= {8'h00, prescaler_select_q};
                default: rdata_q <= 16'h0000;
            endcase
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    a_stop_clears: assert property (!running |=> count_value_q == 16'h0000) else $error("count not cleared");
    a_count_step: assert property (tick && !clr_evt |=> count_value_q == $past(count_value_q) + 16'h0001)
        else $error("count did not step");
    a_read_hold: assert property (read_cnt && running && !req.wr && !clr_evt && !pend_q
        |=> count_value_q == $past(count_value_q)) else $error("count moved during read");
    a_edge_clear: assert property (mode == TCC16_CLEAR_EDGE && edge_a_hit |=> count_value_q == 16'h0000)
        else $error("edge clear missed");
    a_match_clear: assert property (mode == TCC16_CLEAR_MATCH && cmp_a_hit |=> count_value_q == 16'h0000)
        else $error("match clear missed");
    a_irq_a_match: assert property (cmp_a_hit |=> match_irq_a) else $error("irq a missed");
    a_irq_b_match: assert property (cmp_b_hit |=> match_irq_b) else $error("irq b missed");
    a_irq_stopped: assert property (!running |=> !match_irq_a && !match_irq_b)
        else $error("irq while stopped");
    a_ovf_wrap: assert property (tick && count_value_q == 16'hFFFF |=> mode_control_q[0])
        else $error("overflow not flagged");
    a_cap_b_load: assert property (cap_b_mode && edge_a_hit |=> capcmp_b_q == $past(count_value_q))
        else $error("capture b wrong");
    a_oneshot_clear: assert property (running && oneshot && sw_trig |=> count_value_q == 16'h0000)
        else $error("one-shot trigger did not clear");
    a_cap_a_load: assert property (cap_a_mode && cap_a_trig |=> capcmp_a_q == $past(count_value_q))
        else $error("capture a wrong");
    a_cap_a_both: assert property (capcmp_control_q[`TCC16_CC_A_SRC_BIT]
        && prescaler_select_q[`TCC16_PRE_EDGE_A_LSB +: 2] == 2'h3 |-> !cap_a_trig)
        else $error("both-edge capture");
    a_byte_ignored: assert property (hit(req, `TCC16_ADDR_CAPCMP_A) && !req.word
        && !(cap_a_mode && cap_a_trig) |=> capcmp_a_q == $past(capcmp_a_q)) else $error("byte write landed");
    a_mode_upper: assert property (mode_control_q[7:4] == 4'h0) else $error("mode upper bits set");
    a_edge_toggle: assert property (output_control_q[`TCC16_OC_TOG_A_BIT] && edge_a_hit
        && mode_control_q[`TCC16_MODE_TIMING_BIT] && !wr_oc |=> lv_q != $past(lv_q))
        else $error("edge toggle missed");
    a_sync_edge: assert property (rise_a |-> $past(ext_input_a, 2)) else $error("edge before sync");

    c_match_clear: cover property (mode == TCC16_CLEAR_MATCH && cmp_a_hit);
    c_overflow: cover property (tick && count_value_q == 16'hFFFF);
    c_capture_a: cover property (cap_a_mode && cap_a_trig);
    c_oneshot: cover property (oneshot && sw_trig && running);
    c_read_hold: cover property (running && raw_tick && read_cnt);

endmodule : tcc16_timer

/* File: design/tcc16_regs.svh */
`ifndef TCC16_REGS_SVH
`define TCC16_REGS_SVH

// Register addresses
`define TCC16_ADDR_COUNT 16'hFF10
`define TCC16_ADDR_CAPCMP_A 16'hFF12
`define TCC16_ADDR_CAPCMP_B 16'hFF14
`define TCC16_ADDR_CAPCMP_CTRL 16'hFF16
`define TCC16_ADDR_MODE_CTRL 16'hFF18
`define TCC16_ADDR_OUTPUT_CTRL 16'hFF1A
`define TCC16_ADDR_PRESCALER 16'hFF1C

// Reset values
`define TCC16_RST_BYTE 8'h00
`define TCC16_RST_WORD 16'h0000

// Mode control fields
`define TCC16_MODE_OVF_BIT 0
`define TCC16_MODE_TIMING_BIT 1
`define TCC16_MODE_SEL_LSB 2
`define TCC16_MODE_WR_MASK 8'h0F

// Capture/compare control fields
`define TCC16_CC_A_CAP_BIT 0
`define TCC16_CC_A_SRC_BIT 1
`define TCC16_CC_B_CAP_BIT 2
`define TCC16_CC_WR_MASK 8'h07

// Output control fields
`define TCC16_OC_ENABLE_BIT 0
`define TCC16_OC_TOG_A_BIT 1
`define TCC16_OC_RESET_BIT 2
`define TCC16_OC_SET_BIT 3
`define TCC16_OC_TOG_B_BIT 4
`define TCC16_OC_ONESHOT_BIT 5
`define TCC16_OC_TRIG_BIT 6
`define TCC16_OC_STORE_MASK 8'h33

// Prescaler fields
`define TCC16_PRE_CLK_LSB 0
`define TCC16_PRE_EDGE_A_LSB 4
`define TCC16_PRE_EDGE_B_LSB 6
`define TCC16_PRE_WR_MASK 8'hF3

// Prescaler tick positions for fxx/4 and fxx/16, and the count maximum
`define TCC16_DIV4_LAST 4'h3
`define TCC16_DIV16_LAST 4'hF
`define TCC16_COUNT_MAX 16'hFFFF

`endif

/* File: design/tcc16_pkg.sv */
package tcc16_pkg;

    typedef enum logic [1:0] {
        TCC16_STOP,
        TCC16_FREE_RUN,
        TCC16_CLEAR_EDGE,
        TCC16_CLEAR_MATCH
    } tcc16_mode_t;

    typedef enum logic [1:0] {
        TCC16_CLK_DIV4,
        TCC16_CLK_DIV16,
        TCC16_CLK_OTHER_IRQ,
        TCC16_CLK_EDGE_A
    } tcc16_clk_sel_t;

    typedef struct packed {
        logic [15:0] addr;
        logic wr;
        logic rd;
        logic word;
        logic [15:0] wdata;
    } tcc16_req_t;

endpackage : tcc16_pkg

/* File: tb/tcc16_pins_model.sv */
`timescale 1ns/1ps
module tcc16_pins_model (
    input wire logic sys_clk,
    output logic ext_input_a,
    output logic ext_input_b
);
    initial begin
        ext_input_a = 1'b1;
        ext_input_b = 1'b0;
    end
    // A level stands for six cycles so the two-stage sync and edge stage see it settle
    task automatic set_a(input logic level);
        @(negedge sys_clk);
        ext_input_a = level;
        repeat (6) @(negedge sys_clk);
    endtask : set_a
    task automatic set_b(input logic level);
        @(negedge sys_clk);
        ext_input_b = level;
        repeat (6) @(negedge sys_clk);
    endtask : set_b
endmodule : tcc16_pins_model

/* File: tb/timer16_capture_compare_test.sv */
`timescale 1ns/1ps
`include "tcc16_regs.svh"
module timer16_capture_compare_test;
    import tcc16_pkg::*;
    logic sys_clk;
    logic reset_n;
    tcc16_req_t req;
    logic [15:0] rdata_q;
    logic ext_input_a;
    logic ext_input_b;
    logic other_timer_irq;
    logic timer_out_pin;
    logic match_irq_a;
    logic match_irq_b;
    logic rd_pend;
    logic [15:0] rd_q[$];
    logic [1:0] irq_q[$];
    int err_count;
    int check_count;
    int seed;
    logic [15:0] v;

    tcc16_timer DUT (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .req(req),
        .rdata_q(rdata_q),
        .ext_input_a(ext_input_a),
        .ext_input_b(ext_input_b),
        .other_timer_irq(other_timer_irq),
        .timer_out_pin(timer_out_pin),
        .match_irq_a(match_irq_a),
        .match_irq_b(match_irq_b)
    );
    tcc16_pins_model pins (
        .sys_clk(sys_clk),
        .ext_input_a(ext_input_a),
        .ext_input_b(ext_input_b)
    );

    initial sys_clk = 1'b0;
    always #5 sys_clk = ~sys_clk;

    task automatic compare(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : compare

    task automatic final_report;
        if (irq_q.size() != 0) begin
            err_count++;
            $display("wrong value at %0t: interrupt never seen", $time);
        end
        if (err_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report

    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic w);
        @(negedge sys_clk);
        req = '{addr: a, wr: 1'b1, rd: 1'b0, word: w, wdata: d};
        @(negedge sys_clk);
        req.wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        rd_q.push_back(e);
        @(negedge sys_clk);
        req = '{addr: a, wr: 1'b0, rd: 1'b1, word: 1'($random(seed)), wdata: 16'($random(seed))};
        @(negedge sys_clk);
        req.rd = 1'b0;
    endtask : rd

    // Ticks are at least two cycles apart so a tick never lands on a count read
    task automatic tick(input int n);
        repeat (n) begin
            @(negedge sys_clk) other_timer_irq = 1'b1;
            @(negedge sys_clk) other_timer_irq = 1'b0;
            repeat (2'($random(seed))) @(negedge sys_clk);
        end
    endtask : tick

    always @(posedge sys_clk) rd_pend <= req.rd;

    // Any interrupt with no note waiting is compared against zero and so reported
    always @(negedge sys_clk) begin
        if (rd_pend === 1'b1) compare(rdata_q, rd_q.pop_front());
        if (match_irq_a === 1'b1 || match_irq_b === 1'b1) begin
            compare({14'h0000, match_irq_b, match_irq_a}, (irq_q.size() != 0) ? {14'h0000, irq_q.pop_front()} : 16'h0000);
        end
    end

    initial begin
        repeat (90000) @(posedge sys_clk);
        err_count++;
        final_report();
    end

    initial begin
        seed = 47880;
        err_count = 0;
        check_count = 0;
        req = '0;
        other_timer_irq = 1'b0;
        reset_n = 1'b0;
        repeat (16) @(negedge sys_clk);
        reset_n = 1'b1;
        rd(`TCC16_ADDR_COUNT, 16'h0000);
        rd(`TCC16_ADDR_CAPCMP_A, 16'h0000);
        rd(`TCC16_ADDR_CAPCMP_B, 16'h0000);
        rd(`TCC16_ADDR_MODE_CTRL, 16'h0000);
        rd(16'hFF1E, 16'h0000);
        tick(3);
        wr(`TCC16_ADDR_MODE_CTRL, 16'h00F0, 1'b0);
        rd(`TCC16_ADDR_MODE_CTRL, 16'h0000);
        v = 16'h8000 | 16'($random(seed));
        wr(`TCC16_ADDR_CAPCMP_A, v, 1'b0);
        rd(`TCC16_ADDR_CAPCMP_A, 16'h0000);
        wr(`TCC16_ADDR_CAPCMP_A, v, 1'b1);
        wr(`TCC16_ADDR_CAPCMP_B, v ^ 16'h4000, 1'b1);
        rd(`TCC16_ADDR_CAPCMP_A, v);
        rd(`TCC16_ADDR_CAPCMP_B, v ^ 16'h4000);
        wr(`TCC16_ADDR_PRESCALER, 16'h0042, 1'b0);
        wr(`TCC16_ADDR_CAPCMP_CTRL, 16'h0005, 1'b0);
        wr(`TCC16_ADDR_MODE_CTRL, 16'h0004, 1'b0);
        tick(4);
        rd(`TCC16_ADDR_COUNT, 16'h0004);
        irq_q.push_back(2'b01);
        pins.set_b(1'b1);
        rd(`TCC16_ADDR_CAPCMP_A, 16'h0004);
        tick(3);
        irq_q.push_back(2'b10);
        pins.set_a(1'b0);
        rd(`TCC16_ADDR_CAPCMP_B, 16'h0007);
        wr(`TCC16_ADDR_OUTPUT_CTRL, 16'h0021, 1'b0);
        wr(`TCC16_ADDR_OUTPUT_CTRL, 16'h0061, 1'b0);
        rd(`TCC16_ADDR_COUNT, 16'h0000);
        rd(`TCC16_ADDR_OUTPUT_CTRL, 16'h0021);
        wr(`TCC16_ADDR_MODE_CTRL, 16'h0000, 1'b0);
        rd(`TCC16_ADDR_COUNT, 16'h0000);
        wr(`TCC16_ADDR_CAPCMP_CTRL, 16'h0000, 1'b0);
        wr(`TCC16_ADDR_CAPCMP_A, 16'h0003, 1'b1);
        wr(`TCC16_ADDR_CAPCMP_B, 16'h0002, 1'b1);
        wr(`TCC16_ADDR_OUTPUT_CTRL, 16'h0003, 1'b0);
        wr(`TCC16_ADDR_MODE_CTRL, 16'h000C, 1'b0);
        for (int i = 0; i < 2; i++) begin
            irq_q.push_back(2'b10);
            irq_q.push_back(2'b01);
            tick(4);
            rd(`TCC16_ADDR_COUNT, 16'h0000);
            compare({15'h0000, timer_out_pin}, (i == 0) ? 16'h0001 : 16'h0000);
        end
        rd(`TCC16_ADDR_MODE_CTRL, 16'h000C);
        wr(`TCC16_ADDR_MODE_CTRL, 16'h0000, 1'b0);
        wr(`TCC16_ADDR_PRESCALER, 16'h0052, 1'b0);
        wr(`TCC16_ADDR_MODE_CTRL, 16'h0008, 1'b0);
        irq_q.push_back(2'b10);
        irq_q.push_back(2'b01);
        tick(5);
        rd(`TCC16_ADDR_COUNT, 16'h0005);
        pins.set_a(1'b1);
        rd(`TCC16_ADDR_COUNT, 16'h0000);
        wr(`TCC16_ADDR_MODE_CTRL, 16'h0000, 1'b0);
        wr(`TCC16_ADDR_PRESCALER, 16'h0002, 1'b0);
        wr(`TCC16_ADDR_CAPCMP_CTRL, 16'h0003, 1'b0);
        wr(`TCC16_ADDR_MODE_CTRL, 16'h0006, 1'b0);
        irq_q.push_back(2'b10);
        tick(3);
        pins.set_a(1'b0);
        compare({15'h0000, timer_out_pin}, 16'h0000);
        irq_q.push_back(2'b01);
        pins.set_a(1'b1);
        rd(`TCC16_ADDR_CAPCMP_A, 16'h0003);
        wr(`TCC16_ADDR_MODE_CTRL, 16'h0000, 1'b0);
        wr(`TCC16_ADDR_PRESCALER, 16'h0000, 1'b0);
        wr(`TCC16_ADDR_MODE_CTRL, 16'h0004, 1'b0);
        irq_q.push_back(2'b10);
        repeat (10) @(negedge sys_clk);
        rd(`TCC16_ADDR_COUNT, 16'h0002);
        rd(`TCC16_ADDR_COUNT, 16'h0003);
        wr(`TCC16_ADDR_MODE_CTRL, 16'h0000, 1'b0);
        wr(`TCC16_ADDR_PRESCALER, 16'h0002, 1'b0);
        wr(`TCC16_ADDR_CAPCMP_CTRL, 16'h0004, 1'b0);
        wr(`TCC16_ADDR_CAPCMP_A, 16'hFFFF, 1'b1);
        wr(`TCC16_ADDR_MODE_CTRL, 16'h000C, 1'b0);
        irq_q.push_back(2'b01);
        @(negedge sys_clk) other_timer_irq = 1'b1;
        repeat (65536) @(negedge sys_clk);
        other_timer_irq = 1'b0;
        rd(`TCC16_ADDR_MODE_CTRL, 16'h000D);
        rd(`TCC16_ADDR_COUNT, 16'h0000);
        repeat (4) @(negedge sys_clk);
        final_report();
    end
endmodule : timer16_capture_compare_test
